//--- rtl/dcl_pkg.sv
package dcl_pkg;

	// ==========================================================
	// Geometry.
	localparam int unsigned DATA_W    = 10;
	localparam int unsigned CHANNELS  = 6;
	localparam logic [2:0]  CH_FIRST  = 3'h0;
	localparam logic [2:0]  CH_LAST   = 3'h5;

	// ==========================================================
	// APB register map, byte addresses.
	localparam logic [7:0]  CTRL_ADDR    = 8'h00;
	localparam logic [7:0]  STATUS_ADDR  = 8'h04;
	localparam logic [7:0]  XFER_ADDR    = 8'h08;
	localparam logic [7:0]  HELD_ADDR    = 8'h10;
	localparam logic [7:0]  OUT_ADDR     = 8'h30;

	// ==========================================================
	// Field positions and reset values.
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam logic        CTRL_RESET      = 1'h1;
	localparam int unsigned STAT_LOAD_BIT   = 0;
	localparam int unsigned STAT_START_BIT  = 1;
	localparam int unsigned STAT_INV_BIT    = 2;
	localparam int unsigned STAT_POL_BIT    = 3;
	localparam int unsigned STAT_CH_LSB     = 4;
	localparam int unsigned STAT_CNT_LSB    = 8;

	typedef enum logic {
		DCL_IDLE,
		DCL_LOAD
	} dcl_state_t;

endpackage

//--- rtl/dcl_loader.sv
// Function
// - Ten-bit pixel data word, bit 9 is the most significant.
// - Sequence start is sampled on every active pixel clock edge.
// - Start sampled high: next active edge loads first word into starting channel.
// - Edge select high picks rising pixel clock edge, low picks falling.
// - While loading, one word per active edge into successive channels.
// - Direction low starts at channel 0, high starts at channel 5.
// - Transfer is detected when high at a rising pixel clock edge.
// - Next rising edge after detection moves all six words to outputs together.
// - Polarity latched on first rising edge after transfer, applied next transfer.
module dcl_loader #(
	parameter int unsigned DATA_W   = dcl_pkg::DATA_W,
	parameter int unsigned CHANNELS = dcl_pkg::CHANNELS
) (
	// System.
	input  wire logic                         clock,
	input  wire logic                         rst_b,
	// Pixel interface from the timing controller.
	input  wire logic                         pixel_clk,
	input  wire logic [DATA_W-1:0]            pixel_data_bus,
	input  wire logic                         sequence_start,
	input  wire logic                         direction_select,
	input  wire logic                         edge_select,
	input  wire logic                         output_transfer,
	input  wire logic                         polarity_invert,
	// Converter side.
	output logic      [CHANNELS*DATA_W-1:0]   column_outputs,
	output logic                              column_polarity,
	// APB slave.
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic                              pready,
	output logic      [31:0]                  prdata,
	output logic                              pslverr
);

	// ==========================================================
	// Pixel clock edge detection.
	// The pixel clock is oversampled by the system clock, so it must run
	// well below half the system rate for every edge to be seen.
	// The last sample resets low, so a pixel clock held high across reset
	// shows one rising edge; the controller should idle it low before release.
	logic                  pclk_q;
	logic                  start_q;
	logic                  xfr_q;
	logic                  enable;
	dcl_pkg::dcl_state_t   state;
	dcl_pkg::dcl_state_t   next_state;
	logic [2:0]            chan;
	logic [2:0]            count;
	logic [DATA_W-1:0]     held [CHANNELS];
	logic                  inv_held;
	logic [15:0]           xfer_count;

	wire rise_edge   = pixel_clk & ~pclk_q;
	wire fall_edge   = ~pixel_clk & pclk_q;
	wire active_edge = enable & (edge_select ? rise_edge : fall_edge);
	// Transfers always follow rising edges, whichever edge loads the words.
	wire xfer_edge   = enable & rise_edge;

	// ==========================================================
	// Channel sequencing.
	// A start seen while a sequence runs restarts it at the first channel, so a
	// controller that has lost its place only has to raise the start input again.
	wire [2:0] first_chan = direction_select ? dcl_pkg::CH_LAST : dcl_pkg::CH_FIRST;
	wire [2:0] step_chan  = direction_select ? chan - 3'h1 : chan + 3'h1;
	wire       seq_begin  = active_edge & start_q;
	wire       seq_step   = active_edge & ~start_q & (state == dcl_pkg::DCL_LOAD);
	wire       load_now   = seq_begin | seq_step;
	wire [2:0] next_chan  = seq_begin ? first_chan : step_chan;
	wire       last_word  = seq_begin ? 1'b0 : (count == 3'(CHANNELS - 1));
	wire [2:0] next_count = seq_begin ? 3'h1 : count + 3'h1;

	// ==========================================================
	// Sequence state.
	// Idle ignores plain active edges; only a sampled start opens a sequence.
	always_comb begin
		next_state = state;
		unique case (state)
			dcl_pkg::DCL_IDLE: begin
				if (seq_begin)
					next_state = dcl_pkg::DCL_LOAD;
			end
			dcl_pkg::DCL_LOAD: begin
				if (seq_step && last_word)
					next_state = dcl_pkg::DCL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pclk_q  <= 1'b0;
			start_q <= 1'b0;
			xfr_q   <= 1'b0;
		end else begin
			pclk_q <= pixel_clk;
			if (active_edge)
				start_q <= sequence_start;
			if (xfer_edge)
				xfr_q <= output_transfer;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= dcl_pkg::DCL_IDLE;
			chan  <= 3'h0;
			count <= 3'h0;
		end else begin
			state <= next_state;
			if (load_now) begin
				chan  <= next_chan;
				count <= next_count;
			end
		end
	end

	// ==========================================================
	// Holding latches and output transfer.
	// A latch keeps its word until a sequence reaches it again, so a transfer
	// after a cut sequence repeats old words in the channels not reached.
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_chan
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b)
					held[g] <= '0;
				else if (load_now && next_chan == 3'(g))
					held[g] <= pixel_data_bus;
			end
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b)
					column_outputs[g*DATA_W +: DATA_W] <= '0;
				else if (xfer_edge && xfr_q)
					column_outputs[g*DATA_W +: DATA_W] <= held[g];
			end
		end
	endgenerate

	// ==========================================================
	// Polarity pipeline.
	// The level waits one transfer, so it is applied together with the words
	// loaded after it was chosen rather than with the line already on show.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			inv_held        <= 1'b0;
			column_polarity <= 1'b0;
			xfer_count      <= 16'h0000;
		end else if (xfer_edge && xfr_q) begin
			// The new level only reaches the outputs at the following transfer.
			column_polarity <= inv_held;
			inv_held        <= polarity_invert;
			xfer_count      <= xfer_count + 16'h0001;
		end
	end

	// ==========================================================
	// APB slave: no wait states, yet every answer comes from a flip-flop loaded during setup.
	// Control sits at the base, then status and transfer count, then six held
	// words and six output words. Any other address, and any write but to
	// control, answers with an error and changes nothing.
	wire        setup    = psel & ~penable;
	wire        wr_fire  = psel & penable & pready & pwrite;
	wire        is_ctrl  = paddr == dcl_pkg::CTRL_ADDR;
	wire        is_stat  = paddr == dcl_pkg::STATUS_ADDR;
	wire        is_xfer  = paddr == dcl_pkg::XFER_ADDR;
	wire [7:0]  held_off = paddr - dcl_pkg::HELD_ADDR;
	wire [7:0]  out_off  = paddr - dcl_pkg::OUT_ADDR;
	wire        is_held  = paddr >= dcl_pkg::HELD_ADDR && held_off < 8'(4 * CHANNELS)
		&& paddr[1:0] == 2'h0;
	wire        is_out   = paddr >= dcl_pkg::OUT_ADDR && out_off < 8'(4 * CHANNELS)
		&& paddr[1:0] == 2'h0;
	wire [2:0]  held_idx = held_off[4:2];
	wire [2:0]  out_idx  = out_off[4:2];
	wire        mapped   = is_ctrl | is_stat | is_xfer | is_held | is_out;
	wire        ro_write = pwrite & ~is_ctrl;

	// ==========================================================
	// Read data selection.
	// Status gathers live state, so a read shows the sequence as it stands.
	logic [31:0] status_word;
	logic [31:0] read_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[dcl_pkg::STAT_LOAD_BIT]                = state == dcl_pkg::DCL_LOAD;
		status_word[dcl_pkg::STAT_START_BIT]               = start_q;
		status_word[dcl_pkg::STAT_INV_BIT]                 = inv_held;
		status_word[dcl_pkg::STAT_POL_BIT]                 = column_polarity;
		status_word[dcl_pkg::STAT_CH_LSB +: 3]             = chan;
		status_word[dcl_pkg::STAT_CNT_LSB +: 3]            = count;
		read_word = 32'h0000_0000;
		if (is_ctrl)
			read_word[dcl_pkg::CTRL_ENABLE_BIT] = enable;
		else if (is_stat)
			read_word = status_word;
		else if (is_xfer)
			read_word[15:0] = xfer_count;
		else if (is_held)
			read_word[DATA_W-1:0] = held[held_idx];
		else if (is_out)
			read_word[DATA_W-1:0] = column_outputs[out_idx*DATA_W +: DATA_W];
	end

	// ==========================================================
	// Response registers.
	// Read data is forced to zero outside a read access, so a stale word never
	// lingers on the bus between transfers.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			enable  <= dcl_pkg::CTRL_RESET;
		end else begin
			pready  <= setup;
			prdata  <= (setup && !pwrite) ? read_word : 32'h0000_0000;
			pslverr <= setup & (~mapped | ro_write);
			if (wr_fire && is_ctrl)
				enable <= pwdata[dcl_pkg::CTRL_ENABLE_BIT];
		end
	end

endmodule // dcl_loader

//--- tb/dcl_loader_monitor.sv
module dcl_loader_monitor #(
	parameter int unsigned DATA_W   = dcl_pkg::DATA_W,
	parameter int unsigned CHANNELS = dcl_pkg::CHANNELS
) (
	// Clock and reset.
	input wire logic                       clock,
	input wire logic                       rst_b,
	// Watched ports.
	input wire logic                       pixel_clk,
	input wire logic [CHANNELS*DATA_W-1:0] column_outputs,
	input wire logic                       column_polarity,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [7:0]                 paddr,
	input wire logic                       pready,
	input wire logic [31:0]                prdata,
	input wire logic                       pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_single; pready |=> !pready; endproperty
	a_single: assert property (p_single) else $error("ready held two cycles");
	property p_quiet; !pready |-> prdata == 32'h0; endproperty
	a_quiet: assert property (p_quiet) else $error("read data outside access");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_hole; pready && paddr == 8'h0c |-> pslverr; endproperty
	a_hole: assert property (p_hole) else $error("unmapped access accepted");
	property p_ro; pready && pwrite && paddr == dcl_pkg::STATUS_ADDR |-> pslverr; endproperty
	a_ro: assert property (p_ro) else $error("status write accepted");
	// Outputs may move only just after a rising pixel edge.
	property p_cols; $changed(column_outputs) |-> $past(pixel_clk) || $past(pixel_clk, 2); endproperty
	a_cols: assert property (p_cols) else $error("outputs moved off a rise");
	property p_pol; $changed(column_polarity) |-> $past(pixel_clk) || $past(pixel_clk, 2); endproperty
	a_pol: assert property (p_pol) else $error("polarity moved off a rise");
endmodule // dcl_loader_monitor

bind dcl_loader dcl_loader_monitor #(.DATA_W(DATA_W), .CHANNELS(CHANNELS)) i_monitor (
	.clock, .rst_b, .pixel_clk, .column_outputs, .column_polarity, .psel,
	.penable, .pwrite, .paddr, .pready, .prdata, .pslverr);

//--- tb/dcl_ctl.sv
module dcl_ctl (
	// System clock.
	input wire logic   clock,
	// Pixel link.
	output logic       pixel_clk,
	output logic [9:0] pixel_data_bus,
	output logic       sequence_start,
	output logic       direction_select,
	output logic       edge_select,
	output logic       output_transfer,
	output logic       polarity_invert
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {pixel_clk, pixel_data_bus, sequence_start, direction_select, edge_select,
		output_transfer, polarity_invert} = 16'h0;
	task automatic half();
		repeat (2) @(posedge clock);
		pixel_clk <= ~pixel_clk;
	endtask
	// Inputs move at the idle level, so they settle long before the active edge.
	task automatic cyc(input logic s, x, input logic [9:0] d);
		sequence_start <= s;
		output_transfer <= x;
		pixel_data_bus <= d;
		half();
		half();
	endtask
	task automatic mode(input logic e, d);
		edge_select <= e;
		direction_select <= d;
		pixel_clk <= ~e;
		repeat (3) @(posedge clock);
	endtask
	// A seventh word is sent to show that the sequence stops after six.
	task automatic line(input logic [9:0] b, input logic p);
		polarity_invert <= p;
		cyc(1'h1, 1'h0, ~b);
		for (int k = 0; k < 7; k++)
			cyc(1'h0, 1'h0, b + 10'(k * 65));
		cyc(1'h0, 1'h1, ~b);
		cyc(1'h0, 1'h0, b);
	endtask
endmodule // dcl_ctl

//--- tb/decimating_column_loader_bench.sv
module decimating_column_loader_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, pixel_clk, sequence_start, direction_select;
	logic        edge_select, output_transfer, polarity_invert, column_polarity;
	logic [9:0]  pixel_data_bus;
	logic [59:0] column_outputs;
	int          miscompares = 0, n_compared = 0;
	always #2.5 clock = ~clock;
	dcl_ctl i_ctl (.clock, .pixel_clk, .pixel_data_bus, .sequence_start, .direction_select,
		.edge_select, .output_transfer, .polarity_invert);
	dcl_loader i_dut (.clock, .rst_b, .pixel_clk, .pixel_data_bus, .sequence_start,
		.direction_select, .edge_select, .output_transfer, .polarity_invert, .column_outputs,
		.column_polarity, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] e, s);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask
	function automatic logic [59:0] expw(input logic [9:0] b, input logic d);
		expw = 60'h0;
		for (int k = 0; k < 6; k++)
			expw[(d ? 5 - k : k) * 10 +: 10] = b + 10'(k * 65);
	endfunction
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clock);
		rst_b <= 1'h1;
		@(posedge clock);
		apb(1'h0, dcl_pkg::CTRL_ADDR, 32'h0);
		chk("enable", 64'h1, rd);
		chk("read error", 64'h0, err);
		apb(1'h0, 8'h0c, 32'h0);
		chk("unmapped", 64'h1, err);
		apb(1'h1, dcl_pkg::STATUS_ADDR, 32'h0);
		chk("read only", 64'h1, err);
		$display("register test done");
		i_ctl.mode(1'h1, 1'h0);
		i_ctl.line(10'h2c1, 1'h1);
		repeat (4) @(posedge clock);
		chk("up", expw(10'h2c1, 1'h0), column_outputs);
		chk("polarity", 64'h0, column_polarity);
		$display("rising test done");
		i_ctl.mode(1'h0, 1'h1);
		i_ctl.line(10'h10e, 1'h0);
		repeat (4) @(posedge clock);
		chk("down", expw(10'h10e, 1'h1), column_outputs);
		chk("polarity", 64'h1, column_polarity);
		apb(1'h0, dcl_pkg::HELD_ADDR, 32'h0);
		chk("held", 64'h253, rd);
		apb(1'h0, dcl_pkg::OUT_ADDR + 8'h14, 32'h0);
		chk("out word", 64'h10e, rd);
		apb(1'h0, dcl_pkg::STATUS_ADDR, 32'h0);
		chk("status count", 64'h6, rd[dcl_pkg::STAT_CNT_LSB +: 3]);
		chk("status low", 64'h1 << dcl_pkg::STAT_POL_BIT, rd[7:0]);
		apb(1'h0, dcl_pkg::XFER_ADDR, 32'h0);
		chk("count", 64'h2, rd);
		$display("falling test done");
		apb(1'h1, dcl_pkg::CTRL_ADDR, 32'h0);
		chk("ctrl write", 64'h0, err);
		i_ctl.line(10'h055, 1'h1);
		repeat (4) @(posedge clock);
		chk("frozen", expw(10'h10e, 1'h1), column_outputs);
		chk("frozen polarity", 64'h1, column_polarity);
		apb(1'h1, dcl_pkg::CTRL_ADDR, 32'h1);
		apb(1'h0, dcl_pkg::XFER_ADDR, 32'h0);
		chk("frozen count", 64'h2, rd);
		$display("disable test done");
		print_verdict();
	end
endmodule // decimating_column_loader_bench
